/* rtl/anb_defines.svh */
// timing, width and field constants for the nor bus host controller
`ifndef ANB_DEFINES_SVH
`define ANB_DEFINES_SVH

`define ANB_CLK_PERIOD_NS     100
`define ANB_RANDOM_ACCESS_NS  70
`define ANB_PAGE_ACCESS_NS    20
`define ANB_WE_PULSE_NS       35
`define ANB_CE_HIGH_NS        30
`define ANB_RST_PULSE_NS      500
`define ANB_RESET_ABORT_NS    25000
`define ANB_RESET_TO_READ_NS  50000
`define ANB_RESET_TO_WRITE_NS 50000
`define ANB_SYNC_CYC          2
`define ANB_CNT_W             12
`define ANB_ADDR_W            25
`define ANB_PIN_ADDR_W        24
`define ANB_DATA_W            16
`define ANB_BLK_W             8
`define ANB_PAGE_LSB_X16      4
`define ANB_PAGE_LSB_X8       5
`define ANB_BLK_LSB_X16       16
`define ANB_BLK_LSB_X8        17
`define ANB_DQ_MSB            15
`define ANB_BYTE_MASK         16'h00FF
`define ANB_OE_X16            16'hFFFF
`define ANB_OE_X8             16'h80FF

`endif

/* rtl/anb_host.sv */
// host controller driving an asynchronous parallel nor flash bus
`timescale 1ns/1ns
`default_nettype none
`include "anb_defines.svh"
module anb_host #(
   parameter int RST_PULSE_NS      = `ANB_RST_PULSE_NS,
   parameter int RESET_ABORT_NS    = `ANB_RESET_ABORT_NS,
   parameter int RESET_TO_READ_NS  = `ANB_RESET_TO_READ_NS,
   parameter int RESET_TO_WRITE_NS = `ANB_RESET_TO_WRITE_NS
) (
   input  wire logic                        core_clk,
   input  wire logic                        rst_n,
   input  wire logic                        req_valid,
   input  wire logic                        req_write,
   input  wire logic [`ANB_ADDR_W-1:0]      req_addr,
   input  wire logic [`ANB_DATA_W-1:0]      req_wdata,
   output logic                             req_ready,
   output logic                             rsp_valid,
   output logic [`ANB_DATA_W-1:0]           rsp_rdata,
   output logic [`ANB_BLK_W-1:0]            rsp_block,
   input  wire logic                        cfg_byte_mode,
   input  wire logic                        cfg_protect_n,
   input  wire logic                        dev_reset_req,
   output logic                             dev_busy,
   output logic                             flash_ce_n,
   output logic                             flash_oe_n,
   output logic                             flash_we_n,
   output logic                             flash_rst_n,
   output logic                             word_mode_pin,
   output logic                             protect_boost_pin,
   output logic [`ANB_PIN_ADDR_W-1:0]       flash_addr,
   input  wire logic [`ANB_DATA_W-1:0]      dq_in,
   output logic [`ANB_DATA_W-1:0]           dq_out,
   output logic [`ANB_DATA_W-1:0]           dq_oe,
   input  wire logic                        ready_busy_n_in
);
   function automatic logic [`ANB_CNT_W-1:0] ns_to_cyc(input int ns);
      int c;
      c = (ns + `ANB_CLK_PERIOD_NS - 1) / `ANB_CLK_PERIOD_NS;
      c = (c < 1) ? 1 : c;
      return c[`ANB_CNT_W-1:0];
   endfunction : ns_to_cyc
   // page tag: address bits above the 16-word page
   function automatic logic [`ANB_ADDR_W-1:0] page_tag(input logic [`ANB_ADDR_W-1:0] a,
                                                      input logic bm);
      return bm ? (a >> `ANB_PAGE_LSB_X8) : (a >> `ANB_PAGE_LSB_X16);
   endfunction : page_tag
   function automatic logic [`ANB_BLK_W-1:0] block_of(input logic [`ANB_ADDR_W-1:0] a,
                                                     input logic bm);
      logic [`ANB_ADDR_W-1:0] s;
      s = bm ? (a >> `ANB_BLK_LSB_X8) : (a >> `ANB_BLK_LSB_X16);
      return s[`ANB_BLK_W-1:0];
   endfunction : block_of
   localparam logic [`ANB_CNT_W-1:0] RAND_CYC  = ns_to_cyc(`ANB_RANDOM_ACCESS_NS)
                                               + `ANB_CNT_W'(`ANB_SYNC_CYC);
   localparam logic [`ANB_CNT_W-1:0] PAGE_CYC  = ns_to_cyc(`ANB_PAGE_ACCESS_NS)
                                               + `ANB_CNT_W'(`ANB_SYNC_CYC);
   localparam logic [`ANB_CNT_W-1:0] WE_CYC    = ns_to_cyc(`ANB_WE_PULSE_NS);
   localparam logic [`ANB_CNT_W-1:0] CEH_CYC   = ns_to_cyc(`ANB_CE_HIGH_NS);
   localparam int                    RST_LO_NS = (RST_PULSE_NS > RESET_ABORT_NS)
                                               ? RST_PULSE_NS : RESET_ABORT_NS;
   localparam logic [`ANB_CNT_W-1:0] RSTL_CYC  = ns_to_cyc(RST_LO_NS);
   localparam logic [`ANB_CNT_W-1:0] RD_REC    = ns_to_cyc(RESET_TO_READ_NS);
   localparam logic [`ANB_CNT_W-1:0] WR_REC    = ns_to_cyc(RESET_TO_WRITE_NS);
   anb_pkg::anb_state_e              state_ff, nxt_state;
   logic [`ANB_CNT_W-1:0]            cnt_ff, nxt_cnt;
   logic [`ANB_CNT_W-1:0]            rec_ff, nxt_rec;
   logic                             page_open_ff, nxt_page_open;
   logic [`ANB_ADDR_W-1:0]           addr_ff, nxt_addr;
   logic [`ANB_DATA_W-1:0]           wdata_ff, nxt_wdata;
   logic                             bm_ff, nxt_bm;
   logic                             rsp_valid_ff, nxt_rsp_valid;
   logic [`ANB_DATA_W-1:0]           rdata_ff, nxt_rdata;
   logic [`ANB_BLK_W-1:0]            blk_ff, nxt_blk;
   logic                             prot_ff;
   logic [`ANB_DATA_W-1:0]           dq_s1_ff, dq_s2_ff;
   logic                             rb_s1_ff, rb_s2_ff;
   logic                             rd_ok, wr_ok, page_hit, close_page;
   // pin inputs pass two flops before use
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         dq_s1_ff <= '0;
         dq_s2_ff <= '0;
         rb_s1_ff <= 1'b1;
         rb_s2_ff <= 1'b1;
         prot_ff  <= 1'b0;
      end
      else
      begin
         dq_s1_ff <= dq_in;
         dq_s2_ff <= dq_s1_ff;
         rb_s1_ff <= ready_busy_n_in;
         rb_s2_ff <= rb_s1_ff;
         prot_ff  <= cfg_protect_n;
      end
   end
   // device stays active while it reports busy, whatever ce shows
   assign dev_busy          = !rb_s2_ff;
   assign protect_boost_pin = prot_ff;
   assign rd_ok    = (rec_ff >= RD_REC);
   assign wr_ok    = (rec_ff >= WR_REC);
   assign page_hit = page_open_ff && (bm_ff == cfg_byte_mode)
                   && (page_tag(req_addr, bm_ff) == page_tag(addr_ff, bm_ff));
   // a page miss or a width change closes the page; ready stays low meanwhile
   assign close_page = page_open_ff && ((bm_ff != cfg_byte_mode)
                     || (req_valid && !req_write && !page_hit));
   assign req_ready = (state_ff == anb_pkg::ST_IDLE) && !dev_reset_req && !close_page
                    && (req_write ? wr_ok : rd_ok);
   always_comb
   begin
      nxt_state     = state_ff;
      nxt_cnt       = cnt_ff;
      nxt_rec       = rec_ff;
      nxt_page_open = page_open_ff;
      nxt_addr      = addr_ff;
      nxt_wdata     = wdata_ff;
      nxt_bm        = bm_ff;
      nxt_rsp_valid = 1'b0;
      nxt_rdata     = rdata_ff;
      nxt_blk       = blk_ff;
      if (state_ff != anb_pkg::ST_RST_LOW && (rec_ff < WR_REC || rec_ff < RD_REC))
      begin
         nxt_rec = rec_ff + `ANB_CNT_W'(1);
      end
      case (state_ff)
         anb_pkg::ST_RST_LOW:
         begin
            // held low long enough to also cover an abort in flight
            nxt_page_open = 1'b0;
            nxt_rec       = '0;
            nxt_cnt       = cnt_ff + `ANB_CNT_W'(1);
            if (cnt_ff >= RSTL_CYC)
            begin
               nxt_state = anb_pkg::ST_RECOVER;
               nxt_cnt   = '0;
            end
         end
         anb_pkg::ST_RECOVER:
         begin
            if (rd_ok)
            begin
               nxt_state = anb_pkg::ST_IDLE;
            end
         end
         anb_pkg::ST_IDLE:
         begin
            nxt_bm = cfg_byte_mode;
            if (dev_reset_req)
            begin
               nxt_state = anb_pkg::ST_RST_LOW;
               nxt_cnt   = '0;
            end
            else if (close_page)
            begin
               // ce high for a cycle so the next read is a full random one
               nxt_page_open = 1'b0;
            end
            else if (req_valid && req_ready)
            begin
               nxt_addr      = req_addr;
               nxt_wdata     = req_wdata;
               nxt_blk       = block_of(req_addr, cfg_byte_mode);
               nxt_cnt       = '0;
               nxt_page_open = page_open_ff && !req_write;
               nxt_state     = req_write ? anb_pkg::ST_WR_SETUP : anb_pkg::ST_RD_WAIT;
            end
         end
         anb_pkg::ST_RD_WAIT:
         begin
            nxt_cnt = cnt_ff + `ANB_CNT_W'(1);
            if (cnt_ff + `ANB_CNT_W'(1) >= (page_open_ff ? PAGE_CYC : RAND_CYC))
            begin
               nxt_rdata     = bm_ff ? (dq_s2_ff & `ANB_BYTE_MASK) : dq_s2_ff;
               nxt_rsp_valid = 1'b1;
               nxt_page_open = 1'b1;
               nxt_state     = anb_pkg::ST_IDLE;
            end
         end
         anb_pkg::ST_WR_SETUP:
         begin
            nxt_state = anb_pkg::ST_WR_PULSE;
            nxt_cnt   = '0;
         end
         anb_pkg::ST_WR_PULSE:
         begin
            // every strobe lasts whole cycles, far above the glitch filter
            nxt_cnt = cnt_ff + `ANB_CNT_W'(1);
            if (cnt_ff + `ANB_CNT_W'(1) >= WE_CYC)
            begin
               nxt_state = anb_pkg::ST_WR_HOLD;
            end
         end
         anb_pkg::ST_WR_HOLD:
         begin
            nxt_state     = anb_pkg::ST_DESEL;
            nxt_cnt       = '0;
            nxt_rsp_valid = 1'b1;
         end
         anb_pkg::ST_DESEL:
         begin
            nxt_cnt = cnt_ff + `ANB_CNT_W'(1);
            if (cnt_ff + `ANB_CNT_W'(1) >= CEH_CYC)
            begin
               nxt_state = anb_pkg::ST_IDLE;
            end
         end
         default:
         begin
            nxt_state = anb_pkg::ST_RST_LOW;
            nxt_cnt   = '0;
         end
      endcase
   end
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_ff     <= anb_pkg::ST_RST_LOW;
         cnt_ff       <= '0;
         rec_ff       <= '0;
         page_open_ff <= 1'b0;
         addr_ff      <= '0;
         wdata_ff     <= '0;
         bm_ff        <= 1'b0;
         rsp_valid_ff <= 1'b0;
         rdata_ff     <= '0;
         blk_ff       <= '0;
      end
      else
      begin
         state_ff     <= nxt_state;
         cnt_ff       <= nxt_cnt;
         rec_ff       <= nxt_rec;
         page_open_ff <= nxt_page_open;
         addr_ff      <= nxt_addr;
         wdata_ff     <= nxt_wdata;
         bm_ff        <= nxt_bm;
         rsp_valid_ff <= nxt_rsp_valid;
         rdata_ff     <= nxt_rdata;
         blk_ff       <= nxt_blk;
      end
   end
   assign rsp_valid = rsp_valid_ff;
   assign rsp_rdata = rdata_ff;
   assign rsp_block = blk_ff;
   // pin drive, all from state flops
   logic wr_phase;
   assign wr_phase      = (state_ff == anb_pkg::ST_WR_SETUP) || (state_ff == anb_pkg::ST_WR_PULSE)
                        || (state_ff == anb_pkg::ST_WR_HOLD);
   assign flash_rst_n   = (state_ff != anb_pkg::ST_RST_LOW);
   // ce stays low between reads only while a page is open, else standby
   assign flash_ce_n    = !(wr_phase || (state_ff == anb_pkg::ST_RD_WAIT)
                            || ((state_ff == anb_pkg::ST_IDLE) && page_open_ff));
   assign flash_oe_n    = (state_ff != anb_pkg::ST_RD_WAIT);
   // address latched at we fall after ce fall, data at we rise before ce rise
   assign flash_we_n    = (state_ff != anb_pkg::ST_WR_PULSE);
   assign word_mode_pin = !bm_ff;
   assign flash_addr    = bm_ff ? addr_ff[`ANB_ADDR_W-1:1]
                                : addr_ff[`ANB_PIN_ADDR_W-1:0];
   always_comb
   begin
      dq_out = wdata_ff;
      dq_oe  = wr_phase ? `ANB_OE_X16 : '0;
      if (bm_ff)
      begin
         dq_out[`ANB_DQ_MSB] = addr_ff[0];
         dq_oe               = wr_phase ? `ANB_OE_X8 : (`ANB_OE_X8 & ~`ANB_BYTE_MASK);
      end
   end
endmodule : anb_host
`default_nettype wire

/* rtl/anb_pkg.sv */
// types for the nor bus host controller
package anb_pkg;
   typedef enum logic [2:0] {
      ST_RST_LOW  = 3'h0,
      ST_RECOVER  = 3'h1,
      ST_IDLE     = 3'h2,
      ST_RD_WAIT  = 3'h3,
      ST_WR_SETUP = 3'h4,
      ST_WR_PULSE = 3'h5,
      ST_WR_HOLD  = 3'h6,
      ST_DESEL    = 3'h7
   } anb_state_e;
endpackage : anb_pkg

/* tb/anb_flash_model.sv */
// behavioural nor flash device seen from its pins
`timescale 1ns/1ns
`default_nettype none
module anb_flash_model #(
   parameter int BUSY_NS = 1000
) (
   input  wire logic        ce_n,
   input  wire logic        oe_n,
   input  wire logic        we_n,
   input  wire logic        rst_pin_n,
   input  wire logic        word_mode,
   input  wire logic [23:0] addr,
   input  wire logic [15:0] dq_host,
   output logic      [15:0] dq_dev,
   output logic             busy_pin_n,
   output logic      [24:0] cmd_addr,
   output logic      [15:0] cmd_data
);
   logic        wr_on;
   logic        reading;
   logic [7:0]  bsel;
   logic [15:0] word;
   logic [15:0] last_q;
   // array content is a fixed address pattern; writes never alter it
   assign word = addr[15:0] ^ {addr[23:16], addr[23:16]} ^ 16'hA5C3;
   assign bsel = dq_host[15] ? word[15:8] : word[7:0];
   assign reading = rst_pin_n && !ce_n && !oe_n && we_n;
   // released lines show the inverse of the last driven value
   assign dq_dev = !reading ? ~last_q : word_mode ? word : {~last_q[15:8], bsel};
   initial
   begin
      last_q = 16'h0000;
      wr_on = 1'b0;
      busy_pin_n = 1'b1;
   end
   always @(reading or word or bsel or word_mode)
      if (reading)
         last_q = word_mode ? word : {last_q[15:8], bsel};
   always @(negedge we_n or negedge ce_n)
      if (!we_n && !ce_n && rst_pin_n)
      begin
         cmd_addr <= word_mode ? {1'b0, addr} : {addr, dq_host[15]};
         wr_on <= 1'b1;
      end
   always @(posedge we_n or posedge ce_n or negedge rst_pin_n)
      if (!rst_pin_n)
      begin
         wr_on <= 1'b0;
         busy_pin_n <= 1'b1;
      end
      else if (wr_on)
      begin
         cmd_data <= word_mode ? dq_host : {8'h00, dq_host[7:0]};
         wr_on <= 1'b0;
         busy_pin_n <= 1'b0;
         busy_pin_n <= #BUSY_NS 1'b1;
      end
endmodule : anb_flash_model
`default_nettype wire

/* tb/anb_host_chk.sv */
// concurrent checks on the nor bus host pins
`timescale 1ns/1ns
`default_nettype none
`include "anb_defines.svh"
module anb_host_chk #(
   parameter int RESET_TO_READ_NS = 300
) (
   input wire logic                   core_clk,
   input wire logic                   rst_n,
   input wire logic                   rsp_valid,
   input wire logic                   flash_ce_n,
   input wire logic                   flash_oe_n,
   input wire logic                   flash_we_n,
   input wire logic                   flash_rst_n,
   input wire logic [`ANB_DATA_W-1:0] dq_out,
   input wire logic [`ANB_DATA_W-1:0] dq_oe
);
   localparam int RD_CYC = (RESET_TO_READ_NS + `ANB_CLK_PERIOD_NS - 1) / `ANB_CLK_PERIOD_NS;
   logic [15:0] rec_cnt_ff;
   logic [15:0] nxt_rec_cnt;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   // cycles since the device reset pin went high, saturating
   always_comb
   begin
      nxt_rec_cnt = rec_cnt_ff;
      if (!flash_rst_n)
         nxt_rec_cnt = 16'h0000;
      else if (rec_cnt_ff != 16'hFFFF)
         nxt_rec_cnt = rec_cnt_ff + 16'h0001;
   end
   always_ff @(posedge core_clk or negedge rst_n)
      if (!rst_n)
         rec_cnt_ff <= 16'h0000;
      else
         rec_cnt_ff <= nxt_rec_cnt;
   property p_read_pins; !flash_oe_n |-> !flash_ce_n && flash_we_n && flash_rst_n; endproperty
   a_read_pins: assert property (p_read_pins) else $error("oe low outside a read");
   property p_read_walk; $fell(flash_oe_n) |-> ##2 !flash_oe_n ##1 (rsp_valid && flash_oe_n); endproperty
   a_read_walk: assert property (p_read_walk) else $error("read answer timing wrong");
   property p_rand_ce; $fell(flash_ce_n) |-> !rsp_valid [*3]; endproperty
   a_rand_ce: assert property (p_rand_ce) else $error("answer before random access time");
   property p_wr_oe; !flash_we_n |-> flash_oe_n && !flash_ce_n && flash_rst_n; endproperty
   a_wr_oe: assert property (p_wr_oe) else $error("oe low or ce high in write pulse");
   property p_wr_walk;
      $fell(flash_we_n) |-> !$past(flash_ce_n) ##1 (flash_we_n && !flash_ce_n) ##1 (flash_ce_n && rsp_valid);
   endproperty
   a_wr_walk: assert property (p_wr_walk) else $error("write strobe order wrong");
   property p_wr_data; $rose(flash_we_n) |-> $stable(dq_out) && (dq_oe[7:0] == 8'hFF); endproperty
   a_wr_data: assert property (p_wr_data) else $error("write data not held at strobe end");
   property p_rd_rec; !flash_oe_n |-> rec_cnt_ff >= RD_CYC; endproperty
   a_rd_rec: assert property (p_rd_rec) else $error("read too soon after device reset");
   property p_rst_quiet; !flash_rst_n |-> flash_ce_n && flash_oe_n && flash_we_n; endproperty
   a_rst_quiet: assert property (p_rst_quiet) else $error("strobes active during device reset");
   c_write: cover property ($fell(flash_we_n));
   c_page_read: cover property ($fell(flash_oe_n) && $past(!flash_ce_n));
   c_dev_reset: cover property ($rose(flash_rst_n));
endmodule : anb_host_chk
bind anb_host anb_host_chk #(.RESET_TO_READ_NS(RESET_TO_READ_NS)) u_chk (
   .core_clk(core_clk), .rst_n(rst_n), .rsp_valid(rsp_valid),
   .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n),
   .flash_rst_n(flash_rst_n), .dq_out(dq_out), .dq_oe(dq_oe)
);
`default_nettype wire

/* tb/anb_host_tb.sv */
// self-checking bench for the nor bus host controller
`timescale 1ns/1ns
`default_nettype none
module anb_host_tb;
   logic        core_clk = 1'b0, rst_n = 1'b0, req_valid = 1'b0, req_write = 1'b0;
   logic        cfg_byte_mode = 1'b0, cfg_protect_n = 1'b1, dev_reset_req = 1'b0;
   logic        req_ready, rsp_valid, dev_busy, flash_ce_n, flash_oe_n, flash_we_n;
   logic        flash_rst_n, word_mode_pin, protect_boost_pin, busy_pin_n;
   logic [24:0] req_addr = 25'h0000000, cmd_addr;
   logic [15:0] req_wdata = 16'h0000, rsp_rdata, dq_pin, dq_dev, dq_out, dq_oe, cmd_data;
   logic [23:0] flash_addr;
   logic [7:0]  rsp_block;
   logic [31:0] seed = 32'h00000021;
   int          error_cnt = 0;
   int          tests_run = 0;
   always #50 core_clk = ~core_clk;
   assign dq_pin = (dq_out & dq_oe) | (dq_dev & ~dq_oe);
   anb_host #(.RST_PULSE_NS(200), .RESET_ABORT_NS(300), .RESET_TO_READ_NS(300),
      .RESET_TO_WRITE_NS(300)) u_dut (
      .core_clk, .rst_n, .req_valid, .req_write, .req_addr, .req_wdata, .req_ready,
      .rsp_valid, .rsp_rdata, .rsp_block, .cfg_byte_mode, .cfg_protect_n, .dev_reset_req,
      .dev_busy, .flash_ce_n, .flash_oe_n, .flash_we_n, .flash_rst_n, .word_mode_pin,
      .protect_boost_pin, .flash_addr, .dq_in(dq_pin), .dq_out, .dq_oe,
      .ready_busy_n_in(busy_pin_n));
   anb_flash_model #(.BUSY_NS(3000)) u_flash (
      .ce_n(flash_ce_n), .oe_n(flash_oe_n), .we_n(flash_we_n), .rst_pin_n(flash_rst_n),
      .word_mode(word_mode_pin), .addr(flash_addr), .dq_host(dq_pin), .dq_dev,
      .busy_pin_n, .cmd_addr, .cmd_data);
   function logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : rnd
   function automatic logic [15:0] exp_rd(input logic bm, input logic [24:0] a);
      logic [23:0] w;
      logic [15:0] v;
      w = bm ? a[24:1] : a[23:0];
      v = w[15:0] ^ {w[23:16], w[23:16]} ^ 16'hA5C3;
      return bm ? {8'h00, a[0] ? v[15:8] : v[7:0]} : v;
   endfunction : exp_rd
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
      end
   endtask : chk
   // one request, returns at the falling edge where the answer pulse shows
   task automatic xfer(input logic w, input logic [24:0] a, input logic [15:0] d);
      int n;
      n = 0;
      @(negedge core_clk);
      req_valid = 1'b1;
      req_write = w;
      req_addr = a;
      req_wdata = d;
      // let the ready decode settle on the new request before looking
      #1;
      while (req_ready !== 1'b1 && n < 2000)
      begin
         @(negedge core_clk);
         n++;
      end
      @(negedge core_clk);
      req_valid = 1'b0;
      n = 0;
      while (rsp_valid !== 1'b1 && n < 20)
      begin
         @(negedge core_clk);
         n++;
      end
   endtask : xfer
   task automatic stop_test();
      $display("checks %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : stop_test
   initial
   begin
      #2000000;
      error_cnt++;
      stop_test();
   end
   initial
   begin
      logic [31:0] r;
      logic [24:0] a;
      logic [24:0] prev;
      logic        bm;
      logic        w;
      prev = 25'h0000000;
      repeat (2) @(negedge core_clk);
      rst_n = 1'b1;
      for (int i = 0; i < 40; i++)
      begin
         r = rnd();
         bm = (i >= 20);
         // accesses 4k and 4k+1 are reads, the second inside the first one's page
         w = (r[31] && i % 4 > 1) || i == 2 || i == 22;
         a = bm ? r[24:0] : {1'b0, r[23:0]};
         if (i % 4 == 1)
            a = bm ? {prev[24:5], a[4:0]} : {prev[24:4], a[3:0]};
         if (i == 0)
            a = 25'h0000000;
         if (i == 19)
            a = 25'h0FFFFFF;
         if (i == 39)
            a = 25'h1FFFFFF;
         cfg_byte_mode = bm;
         r = rnd();
         xfer(w, a, r[15:0]);
         prev = a;
         chk("rsp_valid", rsp_valid, 1'b1);
         chk("rsp_block", rsp_block, bm ? a[24:17] : a[23:16]);
         chk("word_mode_pin", word_mode_pin, !bm);
         if (w)
         begin
            chk("cmd_addr", cmd_addr, bm ? a : {1'b0, a[23:0]});
            chk("cmd_data", cmd_data, bm ? {8'h00, r[7:0]} : r[15:0]);
         end
         else
            chk("rsp_rdata", rsp_rdata, exp_rd(bm, a));
      end
      xfer(1'b1, 25'h0000AAA, 16'h00F0);
      repeat (3) @(negedge core_clk);
      chk("dev_busy", dev_busy, 1'b1);
      dev_reset_req = 1'b1;
      @(negedge core_clk);
      dev_reset_req = 1'b0;
      repeat (2) @(negedge core_clk);
      chk("flash_rst_n", flash_rst_n, 1'b0);
      repeat (2) @(negedge core_clk);
      chk("dev_busy", dev_busy, 1'b0);
      xfer(1'b0, 25'h0000123, 16'h0000);
      chk("rsp_rdata", rsp_rdata, exp_rd(1'b1, 25'h0000123));
      cfg_protect_n = 1'b0;
      repeat (2) @(negedge core_clk);
      chk("protect_boost_pin", protect_boost_pin, 1'b0);
      cfg_protect_n = 1'b1;
      repeat (2) @(negedge core_clk);
      chk("protect_boost_pin", protect_boost_pin, 1'b1);
      stop_test();
   end
endmodule : anb_host_tb
`default_nettype wire
